// ### bsfs_defs.svh
/*
  timing counts and codes shared by the startup and fault sequencer.
  assumes a 200 MHz internal clock (5 ns period).
*/
`ifndef BSFS_DEFS_SVH
`define BSFS_DEFS_SVH

`define BSFS_CLK_KHZ 200000
`define BSFS_CAL_TOTAL_US 1900
`define BSFS_SENSE_US 1100
`define BSFS_COMP_LOW_US 800
`define BSFS_SENSE_CYC ((`BSFS_SENSE_US * `BSFS_CLK_KHZ) / 1000)
`define BSFS_COMP_LOW_CYC ((`BSFS_COMP_LOW_US * `BSFS_CLK_KHZ) / 1000)
`define BSFS_LIMIT_SAMPLES 2
`define BSFS_FAULT_TRIP 3
`define BSFS_IDLE_RUN 4
`define BSFS_IDLE_START 5
`define BSFS_FREQ_500K 2'h0
`define BSFS_FREQ_300K 2'h1
`define BSFS_FREQ_1M 2'h2

`endif

// ### bsfs_pkg.sv
/*
  types of the startup and fault sequencer.
  assumes bsfs_defs.svh is compiled with it.
*/
`default_nettype none
package bsfs_pkg;
  typedef enum logic [3:0] {
    ST_OFF = 4'h0,
    ST_CAL_SENSE = 4'h1,
    ST_CAL_PRECOND = 4'h2,
    ST_DISCHARGE = 4'h3,
    ST_RAMP_OFFSET = 4'h4,
    ST_RAMP = 4'h5,
    ST_RUN = 4'h6,
    ST_HICCUP = 4'h7,
    ST_THERMAL = 4'h8
  } bsfs_state_e;
endpackage
`default_nettype wire

// ### bsfs_fault_counter.sv
/*
  overcurrent up/down counter, one step per switching cycle.
  assumes cycle_end is a one-cycle pulse at each switching period end.
*/
`include "bsfs_defs.svh"
`default_nettype none
module bsfs_fault_counter #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // control
  input wire logic clear,
  input wire logic cycle_end,
  input wire logic oc_seen,
  // result
  output logic trip
);
  logic [WIDTH-1:0] count_reg;

  // the trip count of three needs at least two bits
  if (WIDTH < 2)
  begin : g_width_check
    $error("fault counter too narrow");
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      count_reg <= '0;
    else if (clear)
      count_reg <= '0;
    else if (cycle_end && oc_seen && !trip)
      count_reg <= count_reg + 1'b1;
    else if (cycle_end && !oc_seen && count_reg != '0)
      count_reg <= count_reg - 1'b1;
  end

  assign trip = (count_reg >= WIDTH'(`BSFS_FAULT_TRIP));

  a_count_up: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cycle_end && oc_seen && !clear && !trip) |=> count_reg == $past(count_reg) + 1'b1)
    else $error("counter did not step up");
  a_count_down: assert property (@(posedge ref_clk) disable iff (!resetn)
    (cycle_end && !oc_seen && !clear && count_reg != '0) |=> count_reg == $past(count_reg) - 1'b1)
    else $error("counter did not step down");
endmodule
`default_nettype wire

// ### bsfs_sequencer.sv
/*
  startup calibration, soft-start phase sequence and overcurrent hiccup
  control of a synchronous buck converter.
  assumes all analog comparator results arrive synchronous to ref_clk.
*/
`include "bsfs_defs.svh"
`default_nettype none
module bsfs_sequencer
  import bsfs_pkg::*;
#(
  parameter int SENSE_CYC = `BSFS_SENSE_CYC,
  parameter int COMP_LOW_CYC = `BSFS_COMP_LOW_CYC,
  parameter int LIMIT_W = 8,
  parameter int CNT_W = 3
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // enable/soft-start comparators
  input wire logic en_start_cmp,
  input wire logic en_shutdown_cmp,
  input wire logic ss_low_level_cmp,
  input wire logic ss_offset_cmp,
  input wire logic ss_above_ref_cmp,
  input wire logic ss_timeout,
  // supply and temperature
  input wire logic supply_lockout_ok,
  input wire logic thermal_hot,
  input wire logic thermal_cool,
  // calibration sensing
  input wire logic comp_no_res,
  input wire logic comp_large_res,
  input wire logic comp_small_res,
  input wire logic [LIMIT_W-1:0] limit_set_pin,
  input wire logic limit_open_cmp,
  // switching cycle and current sensing
  input wire logic cycle_end,
  input wire logic low_side_on,
  input wire logic [LIMIT_W:0] low_side_drop,
  input wire logic high_side_over,
  // feedback window
  input wire logic feedback_node_out_of_window,
  // controls toward analog
  output logic internal_bias_regulator,
  output logic ss_clamp,
  output logic ss_discharge,
  output logic ss_charge,
  output logic comp_pull_low,
  output logic [1:0] freq_sel,
  output logic ref_from_ramp,
  output logic switching_enable,
  output logic pulse_terminate,
  output logic [LIMIT_W:0] trip_level,
  output logic overcurrent_protection,
  output logic output_ok_flag,
  output logic fault_active
);
  bsfs_state_e state_reg;
  bsfs_state_e state_next;
  logic [31:0] timer_reg;
  logic [1:0] sample_cnt_reg;
  logic [LIMIT_W:0] trip_level_reg;
  logic ocp_en_reg;
  logic [2:0] idle_cnt_reg;
  logic startup_fault_reg;
  logic [LIMIT_W:0] valley_reg;
  logic oc_seen;
  logic trip;
  logic short_seen_reg;
  logic power_ok;

  if (SENSE_CYC < 1 || COMP_LOW_CYC < 1 || LIMIT_W < 2 || CNT_W < 2)
  begin : g_param_check
    $error("sequencer parameters out of range");
  end

  // shutdown level or lockout cancels everything, which also restarts calibration
  assign power_ok = en_start_cmp && !en_shutdown_cmp && supply_lockout_ok;

  function automatic logic [1:0] freq_decode(input logic none_r, input logic large_r, input logic small_r);
    // open pin and unknown impedance both fall back to the default rate
    if (large_r && !none_r)
      freq_decode = `BSFS_FREQ_300K;
    else if (small_r && !none_r)
      freq_decode = `BSFS_FREQ_1M;
    else
      freq_decode = `BSFS_FREQ_500K;
  endfunction

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF:
        if (power_ok && !thermal_hot)
          state_next = ST_CAL_SENSE;
      ST_CAL_SENSE:
        if (timer_reg >= 32'(SENSE_CYC - 1))
          state_next = ST_CAL_PRECOND;
      ST_CAL_PRECOND:
        if (timer_reg >= 32'(COMP_LOW_CYC - 1))
          state_next = ST_DISCHARGE;
      ST_DISCHARGE:
        if (ss_low_level_cmp)
          state_next = ST_RAMP_OFFSET;
      ST_RAMP_OFFSET:
        if (ss_offset_cmp)
          state_next = ST_RAMP;
      ST_RAMP:
        if (trip)
          state_next = ST_HICCUP;
        else if (ss_above_ref_cmp)
          state_next = ST_RUN;
      ST_RUN:
        if (trip)
          state_next = ST_HICCUP;
      ST_HICCUP:
        if (ss_timeout && idle_cnt_reg == 3'(startup_fault_reg ? `BSFS_IDLE_START - 1 : `BSFS_IDLE_RUN - 1))
          state_next = ST_DISCHARGE;
      ST_THERMAL:
        if (thermal_cool)
          state_next = ST_DISCHARGE;
      default:
        state_next = ST_OFF;
    endcase
    if (!power_ok)
      state_next = ST_OFF;
    else if (thermal_hot && state_reg != ST_OFF && state_reg != ST_CAL_SENSE && state_reg != ST_CAL_PRECOND)
      state_next = ST_THERMAL;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      state_reg <= ST_OFF;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      timer_reg <= '0;
    else if (state_next != state_reg)
      timer_reg <= '0;
    else
      timer_reg <= timer_reg + 32'h1;
  end

  // limit sampled twice during sensing; the open level wins over any later sample
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sample_cnt_reg <= '0;
      trip_level_reg <= '0;
      ocp_en_reg <= 1'b0;
    end
    else if (state_reg == ST_OFF)
    begin
      sample_cnt_reg <= '0;
      ocp_en_reg <= 1'b1;
    end
    else if (state_reg == ST_CAL_SENSE && sample_cnt_reg < 2'(`BSFS_LIMIT_SAMPLES)
             && timer_reg == 32'(((32'(sample_cnt_reg) + 1) * SENSE_CYC) / 3))
    begin
      sample_cnt_reg <= sample_cnt_reg + 2'h1;
      trip_level_reg <= {limit_set_pin, 1'b0};
      if (limit_open_cmp)
        ocp_en_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      freq_sel <= `BSFS_FREQ_500K;
    else if (state_reg == ST_CAL_SENSE)
      freq_sel <= freq_decode(comp_no_res, comp_large_res, comp_small_res);
  end

  // valley held from the low-side on interval, compared at the cycle end
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      valley_reg <= '0;
    else if (low_side_on)
      valley_reg <= low_side_drop;
  end

  assign oc_seen = ocp_en_reg && (high_side_over || valley_reg > trip_level_reg);

  bsfs_fault_counter #(
    .WIDTH(CNT_W)
  ) u_fault_counter (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .clear(state_reg != ST_RAMP && state_reg != ST_RUN),
    .cycle_end(cycle_end),
    .oc_seen(oc_seen),
    .trip(trip)
  );

  // dummy timeouts are counted here; the real restart is the discharge that follows them
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      idle_cnt_reg <= '0;
      startup_fault_reg <= 1'b0;
    end
    else if (state_reg != ST_HICCUP && state_next == ST_HICCUP)
    begin
      idle_cnt_reg <= '0;
      startup_fault_reg <= (state_reg == ST_RAMP);
    end
    else if (state_reg == ST_HICCUP && ss_timeout)
      idle_cnt_reg <= idle_cnt_reg + 3'h1;
  end

  // short flag keeps output ok low for a cycle after a trip, even if the count falls again
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      short_seen_reg <= 1'b0;
    else
      short_seen_reg <= trip || state_next == ST_HICCUP;
  end

  // the state outputs follow state_next so they change at the same edge as state_reg
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      internal_bias_regulator <= 1'b0;
      ss_clamp <= 1'b0;
      ss_discharge <= 1'b0;
      ss_charge <= 1'b0;
      comp_pull_low <= 1'b0;
      ref_from_ramp <= 1'b0;
      switching_enable <= 1'b0;
      pulse_terminate <= 1'b0;
      trip_level <= '0;
      overcurrent_protection <= 1'b0;
      output_ok_flag <= 1'b0;
      fault_active <= 1'b0;
    end
    else
    begin
      internal_bias_regulator <= state_next != ST_OFF;
      ss_clamp <= state_next == ST_CAL_SENSE || state_next == ST_CAL_PRECOND;
      ss_discharge <= state_next == ST_DISCHARGE || state_next == ST_HICCUP;
      ss_charge <= state_next == ST_RAMP_OFFSET || state_next == ST_RAMP || state_next == ST_RUN;
      comp_pull_low <= state_next == ST_CAL_PRECOND;
      ref_from_ramp <= state_next == ST_RAMP_OFFSET || state_next == ST_RAMP;
      switching_enable <= state_next == ST_RAMP || state_next == ST_RUN;
      pulse_terminate <= ocp_en_reg && high_side_over;
      trip_level <= trip_level_reg;
      overcurrent_protection <= ocp_en_reg;
      output_ok_flag <= state_next == ST_RUN && !feedback_node_out_of_window && !short_seen_reg;
      fault_active <= state_next == ST_HICCUP;
    end
  end

  // every check below runs on ref_clk and is quiet while resetn is low
  a_cal_sense_len: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(state_reg == ST_CAL_SENSE) |-> (state_reg == ST_CAL_SENSE || !power_ok)[*8])
    else $error("sensing ended too soon");
  a_comp_low: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_reg == ST_CAL_PRECOND && power_ok && !thermal_hot) |=> comp_pull_low || state_reg != ST_CAL_PRECOND)
    else $error("comp pin not pulled low");
  a_no_early_switch: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_reg == ST_RAMP_OFFSET) |=> !switching_enable || state_reg == ST_RAMP)
    else $error("switching before offset crossed");
  a_open_disables: assert property (@(posedge ref_clk) disable iff (!resetn)
    !ocp_en_reg |-> !trip && !fault_active)
    else $error("fault raised with protection off");
  a_hiccup_entry: assert property (@(posedge ref_clk) disable iff (!resetn)
    (trip && (state_reg == ST_RUN || state_reg == ST_RAMP) && power_ok && !thermal_hot)
      |=> state_reg == ST_HICCUP ##1 fault_active)
    else $error("fault did not enter hiccup");
  a_hiccup_count: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_reg == ST_HICCUP && state_next == ST_DISCHARGE)
      |-> idle_cnt_reg == (startup_fault_reg ? 3'h4 : 3'h3))
    else $error("wrong number of idle timeouts");
  a_ok_low_ramp: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_reg != ST_RUN) |-> !output_ok_flag)
    else $error("output ok outside regulation");
  a_thermal_off: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_reg == ST_THERMAL && !thermal_cool) |=> !switching_enable)
    else $error("fets not held off when hot");
  a_pulse_limit: assert property (@(posedge ref_clk) disable iff (!resetn)
    (ocp_en_reg && high_side_over) |=> pulse_terminate)
    else $error("high-side pulse not ended");
  a_bias_off: assert property (@(posedge ref_clk) disable iff (!resetn)
    !power_ok |=> !internal_bias_regulator)
    else $error("bias on without enable and supply");
  a_trip_held: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_reg != ST_CAL_SENSE) |=> $stable(trip_level_reg))
    else $error("trip level changed after calibration");
  a_clamp_cal: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_reg == ST_CAL_SENSE || state_reg == ST_CAL_PRECOND) |-> ss_clamp && !ss_charge)
    else $error("soft-start node not clamped in calibration");
  a_switch_states: assert property (@(posedge ref_clk) disable iff (!resetn)
    switching_enable |-> (state_reg == ST_RAMP || state_reg == ST_RUN))
    else $error("switching outside ramp or run");
  a_ref_handover: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_reg == ST_RUN) |-> !ref_from_ramp)
    else $error("ramp still steering after hand-over");
  a_freq_legal: assert property (@(posedge ref_clk) disable iff (!resetn)
    freq_sel != 2'h3)
    else $error("unused frequency code");

  c_reach_run: cover property (@(posedge ref_clk) disable iff (!resetn) state_reg == ST_RUN);
  c_hiccup_run: cover property (@(posedge ref_clk) disable iff (!resetn)
    state_reg == ST_RUN ##1 state_reg == ST_HICCUP);
  c_restart: cover property (@(posedge ref_clk) disable iff (!resetn)
    state_reg == ST_HICCUP ##1 state_reg == ST_DISCHARGE);
  c_thermal: cover property (@(posedge ref_clk) disable iff (!resetn) state_reg == ST_THERMAL);
  c_start_fault: cover property (@(posedge ref_clk) disable iff (!resetn)
    state_reg == ST_RAMP ##1 state_reg == ST_HICCUP);
endmodule
`default_nettype wire

// ### bsfs_analog_model.sv
/*
  behavioural model of the soft-start pin, its capacitor and its comparators.
  assumes the sequencer's clamp/discharge outputs drive it; node held in 10 mV units.
*/
`default_nettype none
module bsfs_analog_model (
  // clock
  input wire logic ref_clk,
  // outside party pulling the pin low
  input wire logic hold_low,
  // pin controls from the sequencer
  input wire logic ss_clamp,
  input wire logic ss_discharge,
  // comparator results
  output logic en_start_cmp,
  output logic en_shutdown_cmp,
  output logic ss_low_level_cmp,
  output logic ss_offset_cmp,
  output logic ss_above_ref_cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  int node = 0;
  logic started = 1'b0;
  // the floating pin and the charge source both raise the node one step a cycle
  always @(posedge ref_clk)
  begin
    if (hold_low)
      node <= 0;
    else if (ss_discharge)
      node <= (node > 2) ? node - 2 : 0;
    else if (ss_clamp)
      node <= (node < 130) ? node + 1 : 130;
    else if (node < 200)
      node <= node + 1;
  end
  // start comparator keeps its state until shutdown, else the discharge would switch it off
  always @(posedge ref_clk)
  begin
    if (node >= 70)
      started <= 1'b1;
    else if (node < 27)
      started <= 1'b0;
  end
  assign en_start_cmp = started;
  assign en_shutdown_cmp = node < 27;
  assign ss_low_level_cmp = node <= 40;
  assign ss_offset_cmp = node > 80;
  assign ss_above_ref_cmp = node > 140;
endmodule
`default_nettype wire

// ### test_bsfs_sequencer.sv
/*
  self-checking bench of the startup and fault sequencer.
  assumes shortened calibration counts and the analog model on the soft-start pin.
*/
`include "bsfs_defs.svh"
`default_nettype none
module test_bsfs_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SENSE = 30;
  localparam int LOW = 20;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic hold_low = 1'b1;
  logic ss_timeout = 1'b0, thermal_hot = 1'b0, thermal_cool = 1'b1, supply_lockout_ok = 1'b1;
  logic comp_no_res = 1'b1, comp_large_res = 1'b0, comp_small_res = 1'b0, limit_open_cmp = 1'b0;
  logic [7:0] limit_set_pin = 8'h19;
  logic cycle_end = 1'b0, low_side_on = 1'b0, high_side_over = 1'b0, feedback_node_out_of_window = 1'b0;
  logic [8:0] low_side_drop = 9'h000;
  logic en_start_cmp, en_shutdown_cmp, ss_low_level_cmp, ss_offset_cmp, ss_above_ref_cmp;
  logic internal_bias_regulator, ss_clamp, ss_discharge, ss_charge, comp_pull_low, ref_from_ramp;
  logic switching_enable, pulse_terminate, overcurrent_protection, output_ok_flag, fault_active;
  logic [1:0] freq_sel;
  logic [8:0] trip_level;
  int errors = 0;
  int n_compared = 0;
  always #2.5 ref_clk = ~ref_clk;

  bsfs_analog_model model (.ref_clk(ref_clk), .hold_low(hold_low), .ss_clamp(ss_clamp),
    .ss_discharge(ss_discharge), .en_start_cmp(en_start_cmp), .en_shutdown_cmp(en_shutdown_cmp),
    .ss_low_level_cmp(ss_low_level_cmp), .ss_offset_cmp(ss_offset_cmp), .ss_above_ref_cmp(ss_above_ref_cmp));

  bsfs_sequencer #(.SENSE_CYC(SENSE), .COMP_LOW_CYC(LOW)) DUT (.ref_clk(ref_clk), .resetn(resetn),
    .en_start_cmp(en_start_cmp), .en_shutdown_cmp(en_shutdown_cmp), .ss_low_level_cmp(ss_low_level_cmp),
    .ss_offset_cmp(ss_offset_cmp), .ss_above_ref_cmp(ss_above_ref_cmp), .ss_timeout(ss_timeout),
    .supply_lockout_ok(supply_lockout_ok), .thermal_hot(thermal_hot), .thermal_cool(thermal_cool),
    .comp_no_res(comp_no_res), .comp_large_res(comp_large_res), .comp_small_res(comp_small_res),
    .limit_set_pin(limit_set_pin), .limit_open_cmp(limit_open_cmp), .cycle_end(cycle_end),
    .low_side_on(low_side_on), .low_side_drop(low_side_drop), .high_side_over(high_side_over),
    .feedback_node_out_of_window(feedback_node_out_of_window),
    .internal_bias_regulator(internal_bias_regulator), .ss_clamp(ss_clamp), .ss_discharge(ss_discharge),
    .ss_charge(ss_charge), .comp_pull_low(comp_pull_low), .freq_sel(freq_sel), .ref_from_ramp(ref_from_ramp),
    .switching_enable(switching_enable), .pulse_terminate(pulse_terminate), .trip_level(trip_level),
    .overcurrent_protection(overcurrent_protection), .output_ok_flag(output_ok_flag),
    .fault_active(fault_active));

  task automatic report_and_stop();
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  function automatic logic pick(input int sel);
    case (sel)
      0: return comp_pull_low;
      1: return ss_discharge;
      2: return switching_enable;
      3: return output_ok_flag;
      default: return internal_bias_regulator;
    endcase
  endfunction

  // bounded wait so a stuck sequence is reported here, not by the watchdog
  task automatic wait_for(input int sel, output int n);
    n = 0;
    while (pick(sel) !== 1'b1 && n < 400)
    begin
      tick(1);
      n++;
    end
    check($sformatf("wait %0d", sel), pick(sel), 1'b1);
  endtask

  task automatic start_up(input int fsel, input logic open_pin);
    int n;
    hold_low = 1'b1;
    tick(4);
    check("bias off", internal_bias_regulator, 1'b0);
    comp_no_res = fsel == 0;
    comp_large_res = fsel == 1;
    comp_small_res = fsel == 2;
    limit_open_cmp = open_pin;
    hold_low = 1'b0;
    wait_for(5, n);
    check("clamp", ss_clamp, 1'b1);
    wait_for(0, n);
    check("sense len", n >= SENSE - 2 && n <= SENSE + 2, 1'b1);
    check("freq", freq_sel, fsel == 0 ? `BSFS_FREQ_500K : fsel == 1 ? `BSFS_FREQ_300K : `BSFS_FREQ_1M);
    check("trip", trip_level, 9'h032);
    check("protect", overcurrent_protection, !open_pin);
    limit_set_pin = 8'h05;
    wait_for(1, n);
    check("low len", n >= LOW - 2 && n <= LOW + 2, 1'b1);
    wait_for(2, n);
    check("offset", ss_offset_cmp, 1'b1);
    check("ramp ref", ref_from_ramp, 1'b1);
    check("charging", ss_charge, 1'b1);
    if (!open_pin)
      check("trip held", trip_level, 9'h032);
    limit_set_pin = 8'h19;
  endtask

  task automatic sw_cycle(input logic hs, input logic [8:0] drop, input logic prot);
    high_side_over = hs;
    low_side_on = 1'b1;
    low_side_drop = drop;
    tick(2);
    check("terminate", pulse_terminate, hs && prot);
    cycle_end = 1'b1;
    tick(1);
    cycle_end = 1'b0;
    low_side_on = 1'b0;
    high_side_over = 1'b0;
    tick(2);
  endtask

  task automatic hiccup(input int runs);
    for (int k = 1; k <= runs; k++)
    begin
      ss_timeout = 1'b1;
      tick(1);
      ss_timeout = 1'b0;
      tick(2);
      check("restart", {fault_active, ss_discharge}, {k != runs, 1'b1});
    end
  endtask

  task automatic settle();
    int n;
    wait_for(3, n);
    check("ref takes over", ref_from_ramp, 1'b0);
    feedback_node_out_of_window = 1'b1;
    tick(3);
    check("window", output_ok_flag, 1'b0);
    feedback_node_out_of_window = 1'b0;
    tick(3);
  endtask

  initial
  begin
    int n;
    tick(6);
    check("reset", {freq_sel, switching_enable, fault_active, internal_bias_regulator}, 9'h000);
    resetn = 1'b1;
    for (int f = 0; f < 3; f++)
    begin
      start_up(f, 1'b0);
      settle();
    end
    // up/down count: 1,0,1,2, equal valley counts down to 1, then 2,3
    sw_cycle(1'b1, 9'h000, 1'b1);
    sw_cycle(1'b0, 9'h000, 1'b1);
    sw_cycle(1'b0, 9'h033, 1'b1);
    sw_cycle(1'b1, 9'h000, 1'b1);
    sw_cycle(1'b0, 9'h032, 1'b1);
    check("no fault", fault_active, 1'b0);
    sw_cycle(1'b0, 9'h040, 1'b1);
    sw_cycle(1'b1, 9'h000, 1'b1);
    check("fault", fault_active, 1'b1);
    hiccup(4);
    settle();
    thermal_cool = 1'b0;
    thermal_hot = 1'b1;
    tick(3);
    check("hot off", switching_enable, 1'b0);
    thermal_hot = 1'b0;
    thermal_cool = 1'b1;
    wait_for(2, n);
    check("hot restart", ss_charge, 1'b1);
    start_up(0, 1'b0);
    repeat (3) sw_cycle(1'b1, 9'h000, 1'b1);
    check("start fault", fault_active, 1'b1);
    hiccup(5);
    start_up(0, 1'b1);
    repeat (3) sw_cycle(1'b1, 9'h1ff, 1'b0);
    check("no sensing", fault_active, 1'b0);
    report_and_stop();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
